// ---- rtl/dis_serializer.sv ----
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - Accept input level only after stable interval.
// - Select pins choose 3 ms, 1 ms, bypass.
// - Capture low loads filtered levels continuously.
// - Capture high blocks parallel loading.
// - Shift on clock rise with enable low.
// - Enable high holds register, ignores clocks.
// - Shift toward output, serial input enters.
// - One eight-stage register, stage per channel.
// - After eight shifts output follows input.
// - Flag low above first trip point.
// - Serial output and flag tri-state above second trip.
// - Flag released, pull-down keeps it low.
//////////////////////////////////////////////////////////////////////////////////////////////////
module dis_serializer #(
  parameter int unsigned LONG_CYC  = dis_pkg::DB_LONG_CYC,
  parameter int unsigned SHORT_CYC = dis_pkg::DB_SHORT_CYC
) (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Field side.
  input  wire logic [dis_pkg::NUM_CH-1:0] field_inputs,
  input  wire logic                       filter_select_low,
  input  wire logic                       filter_select_high,
  // Host serial pins.
  input  wire logic                       parallel_capture_n,
  input  wire logic                       shift_enable_n,
  input  wire logic                       serial_clock,
  input  wire logic                       chain_serial_in,
  output logic                            chain_serial_out,
  output logic                            chain_serial_out_oe,
  // Temperature monitor.
  input  wire logic [7:0]                 die_temp_c,
  output logic                            overtemp_flag_n,
  output logic                            overtemp_flag_n_oe,
  // Capture history stream.
  output logic                            sample_valid,
  input  wire logic                       sample_ready,
  output logic [dis_pkg::NUM_CH-1:0]      sample_data,
  output logic                            sample_dropped_ff
);
  import dis_pkg::*;

  localparam int unsigned CW = $clog2(LONG_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] field_meta_ff;
  logic [NUM_CH-1:0] field_sync_ff;
  dis_ctl_t          ctl_meta_ff;
  dis_ctl_t          ctl_ff;
  logic [1:0]        sel_meta_ff;
  logic [1:0]        sel_ff;
  logic              sclk_prev_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      field_meta_ff <= '0;
      field_sync_ff <= '0;
      ctl_meta_ff   <= '{capture_n: 1'b1, shift_en_n: 1'b1, sclk: 1'b0, serial_in: 1'b1};
      ctl_ff        <= '{capture_n: 1'b1, shift_en_n: 1'b1, sclk: 1'b0, serial_in: 1'b1};
      sel_meta_ff   <= 2'h3;
      sel_ff        <= 2'h3;
      sclk_prev_ff  <= 1'b0;
    end else begin
      field_meta_ff <= field_inputs;
      field_sync_ff <= field_meta_ff;
      ctl_meta_ff   <= '{capture_n: parallel_capture_n, shift_en_n: shift_enable_n,
                         sclk: serial_clock, serial_in: chain_serial_in};
      ctl_ff        <= ctl_meta_ff;
      sel_meta_ff   <= {filter_select_high, filter_select_low};
      sel_ff        <= sel_meta_ff;
      sclk_prev_ff  <= ctl_ff.sclk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Debounce selection.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  dis_db_mode_t db_mode;
  logic [CW-1:0] db_limit;

  // The select pins read high when left open.
  always_comb begin
    db_mode = DIS_DB_RSVD;
    if (sel_ff == 2'h3) begin
      db_mode = DIS_DB_3MS;
    end else if (sel_ff == 2'h2) begin
      db_mode = DIS_DB_1MS;
    end else if (sel_ff == 2'h1) begin
      db_mode = DIS_DB_BYPASS;
    end
  end

  // The reserved code falls back to the longest interval, the safest reading.
  always_comb begin
    db_limit = CW'(LONG_CYC);
    case (db_mode)
      DIS_DB_3MS:    db_limit = CW'(LONG_CYC);
      DIS_DB_1MS:    db_limit = CW'(SHORT_CYC);
      DIS_DB_BYPASS: db_limit = '0;
      default:       db_limit = CW'(LONG_CYC);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Debounce filters, one per channel.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] stable_ff;
  logic [NUM_CH-1:0] filtered_levels;
  logic [CW-1:0]     db_cnt_ff [NUM_CH];

  for (genvar i = 0; i < NUM_CH; i++) begin : g_db
    always_ff @(posedge clk) begin
      if (!resetn) begin
        stable_ff[i] <= 1'b0;
        db_cnt_ff[i] <= '0;
      end else if (field_sync_ff[i] == stable_ff[i]) begin
        db_cnt_ff[i] <= '0;
      end else if (db_cnt_ff[i] + 1'b1 >= db_limit) begin
        stable_ff[i] <= field_sync_ff[i];
        db_cnt_ff[i] <= '0;
      end else begin
        db_cnt_ff[i] <= CW'(db_cnt_ff[i] + 1'b1);
      end
    end
  end

  // In bypass the raw synchronised level goes straight through.
  assign filtered_levels = (db_mode == DIS_DB_BYPASS) ? field_sync_ff : stable_ff;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Shift register.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  logic [NUM_CH-1:0] shift_ff;
  logic [NUM_CH-1:0] nxt_shift;
  logic              sclk_rise;
  logic              do_shift;

  assign sclk_rise = ctl_ff.sclk && !sclk_prev_ff;
  assign do_shift  = ctl_ff.capture_n && !ctl_ff.shift_en_n && sclk_rise;

  // Stage 0 takes the serial input; the top stage feeds the output.
  always_comb begin
    nxt_shift = shift_ff;
    if (!ctl_ff.capture_n) begin
      nxt_shift = filtered_levels;
    end else if (do_shift) begin
      nxt_shift = {shift_ff[NUM_CH-2:0], ctl_ff.serial_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift_ff <= SHIFT_RST;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Temperature monitor and output drivers.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  logic hot_ff;
  logic shdn_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hot_ff  <= 1'b0;
      shdn_ff <= 1'b0;
    end else begin
      hot_ff  <= (die_temp_c > 8'(TEMP_WARN_C));
      shdn_ff <= (die_temp_c > 8'(TEMP_SHDN_C));
    end
  end

  // The serial output follows the top stage every cycle, with no clock edge needed.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chain_serial_out    <= 1'b0;
      chain_serial_out_oe <= 1'b0;
      overtemp_flag_n     <= 1'b1;
      overtemp_flag_n_oe  <= 1'b0;
    end else begin
      chain_serial_out    <= nxt_shift[NUM_CH-1];
      chain_serial_out_oe <= !shdn_ff;
      overtemp_flag_n     <= !hot_ff;
      overtemp_flag_n_oe  <= !shdn_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Capture history: one word per falling capture edge.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  logic cap_prev_ff;
  logic fifo_in_ready;
  logic cap_fall;

  assign cap_fall = cap_prev_ff && !ctl_ff.capture_n;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_prev_ff       <= 1'b1;
      sample_dropped_ff <= 1'b0;
    end else begin
      cap_prev_ff <= ctl_ff.capture_n;
      if (cap_fall && !fifo_in_ready) begin
        sample_dropped_ff <= 1'b1;
      end
    end
  end

  dis_fifo #(
    .WIDTH (NUM_CH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (cap_fall),
    .in_ready  (fifo_in_ready),
    .in_data   (filtered_levels),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  //////////////////////////////////////////////////////////////////////////////////////////////////
  property p_load;
    @(posedge clk) disable iff (!resetn)
    !ctl_ff.capture_n |=> shift_ff == $past(filtered_levels);
  endproperty
  a_load: assert property (p_load) else $error("capture low did not load");

  property p_block;
    @(posedge clk) disable iff (!resetn)
    ctl_ff.capture_n && !do_shift |=> $stable(shift_ff);
  endproperty
  a_block: assert property (p_block) else $error("register changed without shift");

  property p_shift;
    @(posedge clk) disable iff (!resetn)
    do_shift |=> shift_ff == {$past(shift_ff[NUM_CH-2:0]), $past(ctl_ff.serial_in)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift result wrong");

  property p_hold;
    @(posedge clk) disable iff (!resetn)
    ctl_ff.capture_n && ctl_ff.shift_en_n && sclk_rise |=> $stable(shift_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("enable high did not hold");

  property p_sout;
    @(posedge clk) disable iff (!resetn)
    ##1 chain_serial_out == shift_ff[NUM_CH-1];
  endproperty
  a_sout: assert property (p_sout) else $error("serial out not top stage");

  property p_db;
    @(posedge clk) disable iff (!resetn)
    $past(db_mode) != DIS_DB_BYPASS && $changed(stable_ff) |->
      (($past(field_sync_ff, 2) ^ stable_ff) & ($past(stable_ff) ^ stable_ff)) == '0;
  endproperty
  a_db: assert property (p_db) else $error("filter took unstable level");

  property p_hot;
    @(posedge clk) disable iff (!resetn)
    die_temp_c > 8'(TEMP_WARN_C) ##1 die_temp_c > 8'(TEMP_WARN_C) |=> !overtemp_flag_n;
  endproperty
  a_hot: assert property (p_hot) else $error("flag not low when hot");

  property p_shdn;
    @(posedge clk) disable iff (!resetn)
    die_temp_c > 8'(TEMP_SHDN_C) |=> ##1 !chain_serial_out_oe && !overtemp_flag_n_oe;
  endproperty
  a_shdn: assert property (p_shdn) else $error("outputs not released at shutdown");

  property p_capout;
    @(posedge clk) disable iff (!resetn)
    !ctl_ff.capture_n |=> chain_serial_out == $past(filtered_levels[NUM_CH-1]);
  endproperty
  a_capout: assert property (p_capout) else $error("capture did not show top stage");

  property p_shout;
    @(posedge clk) disable iff (!resetn)
    do_shift |=> chain_serial_out == $past(shift_ff[NUM_CH-2]);
  endproperty
  a_shout: assert property (p_shout) else $error("output missed next stage");

  property p_bypass;
    @(posedge clk) disable iff (!resetn)
    db_mode == DIS_DB_BYPASS |=> stable_ff == $past(field_sync_ff);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not pass level");

  property p_cnt;
    @(posedge clk) disable iff (!resetn)
    db_cnt_ff[0] < CW'(LONG_CYC);
  endproperty
  a_cnt: assert property (p_cnt) else $error("filter count out of range");

  property p_cool;
    @(posedge clk) disable iff (!resetn)
    die_temp_c <= 8'(TEMP_WARN_C) |=> ##1 overtemp_flag_n;
  endproperty
  a_cool: assert property (p_cool) else $error("flag low while cool");

  property p_oe_on;
    @(posedge clk) disable iff (!resetn)
    die_temp_c <= 8'(TEMP_SHDN_C) |=> ##1 chain_serial_out_oe && overtemp_flag_n_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs released below shutdown");

  // Shutdown releases the flag pin while the value behind it stays low.
  property p_flag_rel;
    @(posedge clk) disable iff (!resetn)
    die_temp_c > 8'(TEMP_SHDN_C) |=> ##1 !overtemp_flag_n && !overtemp_flag_n_oe;
  endproperty
  a_flag_rel: assert property (p_flag_rel) else $error("flag not released low");

  property p_rst_oe;
    @(posedge clk)
    !resetn |=> !chain_serial_out_oe && !overtemp_flag_n_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("outputs driven after reset");

  property p_stand;
    @(posedge clk) disable iff (!resetn)
    sample_valid && !sample_ready |=> sample_valid && $stable(sample_data);
  endproperty
  a_stand: assert property (p_stand) else $error("stream word did not stand");

  property p_drop_set;
    @(posedge clk) disable iff (!resetn)
    cap_fall && !fifo_in_ready |=> sample_dropped_ff;
  endproperty
  a_drop_set: assert property (p_drop_set) else $error("lost word not flagged");

  property p_drop_keep;
    @(posedge clk) disable iff (!resetn)
    sample_dropped_ff |=> sample_dropped_ff;
  endproperty
  a_drop_keep: assert property (p_drop_keep) else $error("drop flag cleared");

endmodule

// ---- rtl/dis_pkg.sv ----
package dis_pkg;

  // Channel count and shift register length.
  localparam int unsigned NUM_CH = 8;

  // System clock rate.
  localparam int unsigned CLK_HZ = 20_000_000;

  // Debounce intervals in milliseconds.
  localparam int unsigned DB_LONG_MS  = 3;
  localparam int unsigned DB_SHORT_MS = 1;
  localparam int unsigned DB_NONE_MS  = 0;

  // Debounce intervals in clock cycles.
  localparam int unsigned DB_LONG_CYC  = DB_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned DB_SHORT_CYC = DB_SHORT_MS * (CLK_HZ / 1000);

  // Temperature trip points in degrees Celsius.
  localparam int unsigned TEMP_WARN_C = 150;
  localparam int unsigned TEMP_SHDN_C = 170;

  // Reset values.
  localparam logic [NUM_CH-1:0] SHIFT_RST = 8'h00;

  // FIFO depth in the sample path.
  localparam int unsigned FIFO_DEPTH = 16;

  // Debounce selection decoded from the two select pins (1 = open).
  typedef enum logic [3:0] {
    DIS_DB_3MS    = 4'b0001,
    DIS_DB_1MS    = 4'b0010,
    DIS_DB_BYPASS = 4'b0100,
    DIS_DB_RSVD   = 4'b1000
  } dis_db_mode_t;

  // Host serial control pins, synchronised.
  typedef struct packed {
    logic capture_n;
    logic shift_en_n;
    logic sclk;
    logic serial_in;
  } dis_ctl_t;

  // Pin drive pair for a tri-stated output.
  typedef struct packed {
    logic level;
    logic oe;
  } dis_pin_t;

endpackage

// ---- rtl/dis_fifo.sv ----
`timescale 1ns/1ns
module dis_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             resetn,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // A word leaves the memory when the output register is empty or being drained.
  // The output register counts toward the depth, so the buffer holds DEPTH words in all.
  assign in_ready = ((count_ff + (AW+1)'(out_valid)) < (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (!out_valid || out_ready) && (count_ff != '0);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
      end
      if (pop) begin
        rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
      end
      if (push && !pop) begin
        count_ff <= (AW+1)'(count_ff + 1'b1);
      end else if (pop && !push) begin
        count_ff <= (AW+1)'(count_ff - 1'b1);
      end
    end
  end

  // Output register: refilled whenever it is empty or being drained.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (!out_valid || out_ready) begin
      out_valid <= pop;
      if (pop) begin
        out_data <= mem_ff[rd_ptr_ff];
      end
    end
  end

endmodule

// ---- tb/dis_host_model.sv ----
`timescale 1ns/1ns
module dis_host_model (
  // Clock and job request.
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] n_bits,
  input  wire logic [1:0] n_idle,
  input  wire logic [3:0] phase,
  input  wire logic       sout_line,
  // Host serial pins.
  output logic            capture_n,
  output logic            shift_enable_n,
  output logic            serial_clock,
  // Sampled bits and job status.
  output logic            bit_valid,
  output logic            bit_data,
  output logic            busy
);
  int i;

  task automatic pulse();
    serial_clock <= 1'b1;
    repeat (phase) @(posedge clk);
    serial_clock <= 1'b0;
    repeat (phase) @(posedge clk);
  endtask

  initial begin
    {capture_n, shift_enable_n, serial_clock, bit_valid, bit_data, busy} = 6'h30;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        capture_n <= 1'b0;
        repeat (4) @(posedge clk);
        capture_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Pulses with the enable high must leave the register alone.
        for (i = 0; i < n_idle; i++) begin
          pulse();
        end
        if (n_bits != 5'h00) begin
          shift_enable_n <= 1'b0;
          repeat (phase) @(posedge clk);
          for (i = 0; i < n_bits; i++) begin
            if (i != 0) pulse();
            bit_data <= sout_line;
            bit_valid <= 1'b1;
            @(posedge clk);
            bit_valid <= 1'b0;
          end
          shift_enable_n <= 1'b1;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
  import dis_pkg::*;
  logic              clk, resetn, sel_lo, sel_hi, cap_n, en_n, sclk, sin, sout, sout_oe;
  logic              flag_n, flag_oe, s_valid, s_ready, dropped, go, busy, bvalid, bdata;
  logic              stall, sout_line, flag_wire, exp_b;
  logic [NUM_CH-1:0] field, s_data, ov, nv;
  logic [7:0]        temp;
  logic [4:0]        n_bits;
  logic [1:0]        n_idle;
  logic [3:0]        phase;
  logic              bit_q[$];
  logic [7:0]        word_q[$];
  int                n_mismatch, num_checks, seed, k;
  logic [1:0]        modes[4] = '{2'b11, 2'b10, 2'b00, 2'b01};
  int                early[4] = '{25, 0, 25, 4};
  logic [7:0]        temps[4] = '{8'h96, 8'h97, 8'haa, 8'hab};
  logic [7:0]        t_exp[4] = '{8'h07, 8'h03, 8'h03, 8'h00};

  // A released serial line shows the inverse; the flag line has a pull-down.
  assign sout_line = sout_oe ? sout : ~sout;
  assign flag_wire = flag_oe ? flag_n : 1'b0;

  dis_serializer #(.LONG_CYC(60), .SHORT_CYC(20)) dut (
    .clk(clk), .resetn(resetn), .field_inputs(field),
    .filter_select_low(sel_lo), .filter_select_high(sel_hi),
    .parallel_capture_n(cap_n), .shift_enable_n(en_n), .serial_clock(sclk),
    .chain_serial_in(sin), .chain_serial_out(sout), .chain_serial_out_oe(sout_oe),
    .die_temp_c(temp), .overtemp_flag_n(flag_n), .overtemp_flag_n_oe(flag_oe),
    .sample_valid(s_valid), .sample_ready(s_ready), .sample_data(s_data),
    .sample_dropped_ff(dropped)
  );
  dis_host_model host (
    .clk(clk), .go(go), .n_bits(n_bits), .n_idle(n_idle), .phase(phase),
    .sout_line(sout_line), .capture_n(cap_n), .shift_enable_n(en_n),
    .serial_clock(sclk), .bit_valid(bvalid), .bit_data(bdata), .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic run_job(input logic chg);
    int t;
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    @(posedge clk);
    for (t = 0; busy === 1'b1 && t < 3000; t++) begin
      @(posedge clk);
      if (chg && t == 30) field <= 8'($random(seed));
    end
    if (t >= 3000) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic readout(input logic [7:0] w, input logic [3:0] ph, input logic chg);
    int i;
    logic b;
    b = 1'($random(seed));
    sin <= b;
    for (i = 0; i < 10; i++) begin
      bit_q.push_back(i < 8 ? w[7 - i] : b);
    end
    word_q.push_back(w);
    n_bits <= 5'h0a;
    n_idle <= 2'($random(seed));
    phase <= ph;
    run_job(chg);
  endtask

  task automatic drain();
    int t;
    for (t = 0; word_q.size() != 0 && t < 2000; t++) begin
      @(posedge clk);
    end
    if (t >= 2000) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  always @(posedge clk) begin
    s_ready <= stall ? 1'b0 : 1'($random(seed));
  end

  // Every sampled bit and stream word retires the oldest noted value.
  always @(posedge clk) begin
    if (bvalid) begin
      exp_b = (bit_q.size() != 0) ? bit_q.pop_front() : 1'bx;
      check({7'h00, bdata}, {7'h00, exp_b});
    end
    if (s_valid && s_ready) begin
      check(s_data, (word_q.size() != 0) ? word_q.pop_front() : 8'hxx);
    end
  end

  initial begin
    seed = 32'hb6dd6fd4;
    {resetn, go, stall, s_ready} = 4'h0;
    {sel_lo, sel_hi, sin} = 3'h7;
    field = 8'h00;
    temp = 8'h19;
    n_bits = 5'h00;
    n_idle = 2'h0;
    phase = 4'h3;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    ov = 8'h00;
    for (k = 0; k < 4; k++) begin
      {sel_hi, sel_lo} <= modes[k];
      nv = ov ^ (8'($random(seed)) | 8'h01);
      repeat (4) @(posedge clk);
      field <= nv;
      repeat (early[k]) @(posedge clk);
      readout((k == 3) ? nv : ov, 4'h3, 1'b0);
      repeat (80) @(posedge clk);
      readout(nv, 4'h7, k == 3);
      ov = nv;
    end
    drain();
    stall <= 1'b1;
    for (k = 0; k < 17; k++) begin
      nv = 8'($random(seed));
      field <= nv;
      repeat (4) @(posedge clk);
      if (k < 16) word_q.push_back(nv);
      if (k == 16) check({7'h00, dropped}, 8'h00);
      n_bits <= 5'h00;
      run_job(1'b0);
    end
    repeat (2) @(posedge clk);
    check({7'h00, dropped}, 8'h01);
    stall <= 1'b0;
    drain();
    check(8'(bit_q.size()), 8'h00);
    for (k = 0; k < 4; k++) begin
      temp <= temps[k];
      repeat (4) @(posedge clk);
      check({5'h00, flag_wire, sout_oe, flag_oe}, t_exp[k]);
    end
    complete_run();
  end
endmodule
